// *** verilog/bank_pkg.sv ***
// Constants for the set/clear/toggle register bank.
// Assumes byte-wide registers on a small single-clock access port.
package bank_pkg;
	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [2:0] OFS_CTRL = 3'h0;
	localparam logic [2:0] OFS_STATUS = 3'h1;
	localparam logic [2:0] OFS_CMD = 3'h2;
	localparam logic [2:0] OFS_DBGCTRL = 3'h3;
	localparam logic [2:0] OFS_DATA = 3'h4;
	localparam logic [2:0] OFS_DATA_SET = 3'h5;
	localparam logic [2:0] OFS_DATA_CLEAR = 3'h6;
	localparam logic [2:0] OFS_DATA_TOGGLE = 3'h7;

	// ------------------------------------------------------------------
	// Field layout and reset values
	// ------------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam logic [7:0] CTRL_MASK = 8'h0F;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] DBG_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] WO_READ = 8'h00;
endpackage

// *** verilog/alias_if.sv ***
// Carrier between the bank decoder and one aliased storage register.
// Assumes at most one write strobe is high in any cycle.
interface alias_if #(parameter int W = 8);
	logic wr_base;
	logic wr_set;
	logic wr_clear;
	logic wr_toggle;
	logic [W-1:0] wdata;
	logic [W-1:0] value;

	modport ctl (output wr_base, wr_set, wr_clear, wr_toggle, wdata,
		input value);
	modport store (input wr_base, wr_set, wr_clear, wr_toggle, wdata,
		output value);
endinterface

// *** verilog/alias_reg.sv ***
// One storage register reachable through base, set, clear and toggle.
// Assumes the decoder raises at most one strobe per cycle.
module alias_reg #(
	parameter int W = 8,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic soft_rst,
	alias_if.store bus
);
	logic [W-1:0] value;
	logic [W-1:0] next_value;

	assign bus.value = value;

	// ------------------------------------------------------------------
	// Next value: only bits written as one move on an alias
	// ------------------------------------------------------------------
	always_comb
	begin
		next_value = value;
		if (soft_rst)
			next_value = RST_VAL;
		else if (bus.wr_base)
			next_value = bus.wdata;
		else if (bus.wr_set)
			next_value = value | bus.wdata;
		else if (bus.wr_clear)
			next_value = value & ~bus.wdata;
		else if (bus.wr_toggle)
			next_value = value ^ bus.wdata;
	end

	// Storage
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			value <= RST_VAL;
		else
			value <= next_value;
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_set_bits: assert property (
		bus.wr_set && !soft_rst |=> (value & $past(bus.wdata))
			== $past(bus.wdata))
		else $error("set alias left a bit clear");
	a_clear_bits: assert property (
		bus.wr_clear && !soft_rst |=> (value & $past(bus.wdata)) == '0)
		else $error("clear alias left a bit set");
	a_toggle_bits: assert property (
		bus.wr_toggle && !soft_rst |=> (value & $past(bus.wdata))
			== (~$past(value) & $past(bus.wdata)))
		else $error("toggle alias did not invert a bit");
	a_zero_kept: assert property (
		(bus.wr_set || bus.wr_clear || bus.wr_toggle) && !soft_rst
		|=> (value & ~$past(bus.wdata))
			== ($past(value) & ~$past(bus.wdata)))
		else $error("alias write moved an unselected bit");
endmodule

// *** verilog/reg_bank.sv ***
// Byte-wide register bank with read/write, read-only, write-only,
// debug and set/clear/toggle aliased registers.
// Assumes a single clock; status_in comes from pins, all else from mclk.
//
// Summary of operation
// - A read/write bit reads back what was last written to it.
// - A read-only bit reads its live value and ignores writes.
// - A write-only bit takes writes and reads as WO_READ, which is zero.
// - Reserved bit positions always read as zero.
// - Power-on reset loads reset values; soft reset does too, except debug control and cmd_value.
// - Base and alias registers read back the same value.
// - A one written to the clear alias clears that stored bit.
// - A one written to the set alias sets that stored bit.
// - A one written to the toggle alias inverts that stored bit.
module reg_bank (
	input wire logic mclk,
	input wire logic rst,
	input wire logic soft_rst,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] status_in,
	output logic [7:0] rdata,
	output logic rd_valid,
	output logic [7:0] ctrl_out,
	output logic [7:0] data_out,
	output logic [7:0] dbg_out,
	output logic cmd_pulse,
	output logic [7:0] cmd_value
);
	logic [7:0] ctrl;
	logic [7:0] next_ctrl;
	logic [7:0] dbg;
	logic [7:0] next_dbg;
	logic [7:0] status_meta;
	logic [7:0] status_sync;
	logic [7:0] next_rdata;
	logic next_rd_valid;
	logic next_cmd_pulse;
	logic [7:0] next_cmd_value;
	logic [7:0] next_data_out;

	alias_if #(.W(bank_pkg::DATA_W)) data_bus ();

	// ------------------------------------------------------------------
	// Aliased data register
	// ------------------------------------------------------------------
	// Strobes are exclusive since one address is decoded per cycle
	assign data_bus.wr_base = wr_en && addr == bank_pkg::OFS_DATA;
	assign data_bus.wr_set = wr_en && addr == bank_pkg::OFS_DATA_SET;
	assign data_bus.wr_clear = wr_en && addr == bank_pkg::OFS_DATA_CLEAR;
	assign data_bus.wr_toggle = wr_en && addr == bank_pkg::OFS_DATA_TOGGLE;
	assign data_bus.wdata = wdata;

	alias_reg #(
		.W(bank_pkg::DATA_W),
		.RST_VAL(bank_pkg::DATA_RST)
	) data_store (
		.mclk(mclk),
		.rst(rst),
		.soft_rst(soft_rst),
		.bus(data_bus)
	);

	// ------------------------------------------------------------------
	// Status pin synchroniser
	// ------------------------------------------------------------------
	// Pins are asynchronous; only status_sync is ever decoded
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			status_meta <= 8'h00;
			status_sync <= 8'h00;
		end
		else
		begin
			status_meta <= status_in;
			status_sync <= status_meta;
		end
	end

	// ------------------------------------------------------------------
	// Control, debug and command next values
	// ------------------------------------------------------------------
	always_comb
	begin
		next_ctrl = ctrl;
		next_dbg = dbg;
		next_cmd_pulse = 1'b0;
		next_cmd_value = cmd_value;
		// Soft reset spares the debug register so a debugger keeps hold
		if (soft_rst)
			next_ctrl = bank_pkg::CTRL_RST;
		else if (wr_en && addr == bank_pkg::OFS_CTRL)
			next_ctrl = wdata & bank_pkg::CTRL_MASK;
		if (wr_en && addr == bank_pkg::OFS_DBGCTRL)
			next_dbg = wdata;
		if (wr_en && addr == bank_pkg::OFS_CMD && !soft_rst)
		begin
			next_cmd_pulse = 1'b1;
			next_cmd_value = wdata;
		end
		next_data_out = data_bus.value;
	end

	// ------------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------------
	always_comb
	begin
		next_rd_valid = rd_en;
		next_rdata = 8'h00;
		if (rd_en)
		begin
			unique case (addr)
				bank_pkg::OFS_CTRL:
					next_rdata = ctrl & bank_pkg::CTRL_MASK;
				bank_pkg::OFS_STATUS:
					next_rdata = status_sync;
				bank_pkg::OFS_CMD:
					next_rdata = bank_pkg::WO_READ;
				bank_pkg::OFS_DBGCTRL:
					next_rdata = dbg;
				bank_pkg::OFS_DATA, bank_pkg::OFS_DATA_SET,
				bank_pkg::OFS_DATA_CLEAR, bank_pkg::OFS_DATA_TOGGLE:
					next_rdata = data_bus.value;
			endcase
		end
	end

	// Register all state and outputs
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ctrl <= bank_pkg::CTRL_RST;
			dbg <= bank_pkg::DBG_RST;
			rdata <= 8'h00;
			rd_valid <= 1'b0;
			cmd_pulse <= 1'b0;
			cmd_value <= 8'h00;
			data_out <= bank_pkg::DATA_RST;
		end
		else
		begin
			ctrl <= next_ctrl;
			dbg <= next_dbg;
			rdata <= next_rdata;
			rd_valid <= next_rd_valid;
			cmd_pulse <= next_cmd_pulse;
			cmd_value <= next_cmd_value;
			data_out <= next_data_out;
		end
	end

	// Outputs mirror flops; one cycle behind the store for data
	assign ctrl_out = ctrl;
	assign dbg_out = dbg;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_rw_readback: assert property (
		wr_en && addr == bank_pkg::OFS_CTRL && !soft_rst
		##1 rd_en && addr == bank_pkg::OFS_CTRL
		|=> rdata == ($past(wdata, 2) & bank_pkg::CTRL_MASK))
		else $error("control did not read back the written value");
	a_ro_status: assert property (
		rd_en && addr == bank_pkg::OFS_STATUS |=> rdata == $past(status_sync))
		else $error("status read differs from the live value");
	a_wo_read: assert property (
		rd_en && addr == bank_pkg::OFS_CMD |=> rd_valid && rdata == 8'h00)
		else $error("write-only read gave a nonzero value");
	a_reserved_zero: assert property (
		rd_en && addr == bank_pkg::OFS_CTRL |=> rdata[7:4] == 4'h0)
		else $error("reserved bits read as nonzero");
	a_soft_reset: assert property (
		soft_rst |=> ctrl == bank_pkg::CTRL_RST
			&& data_bus.value == bank_pkg::DATA_RST)
		else $error("soft reset did not restore reset values");
	a_dbg_kept: assert property (
		soft_rst && !(wr_en && addr == bank_pkg::OFS_DBGCTRL)
		|=> $stable(dbg))
		else $error("soft reset changed the debug register");
	a_alias_same: assert property (
		rd_en && addr[2] |=> rdata == $past(data_bus.value))
		else $error("alias read differs from base value");
	a_cmd_pulse: assert property (
		cmd_pulse |=> !cmd_pulse || $past(wr_en && addr == bank_pkg::OFS_CMD))
		else $error("command pulse held without a new write");
	// Write paths land one edge after they are taken
	a_ctrl_write: assert property (
		wr_en && addr == bank_pkg::OFS_CTRL && !soft_rst
		|=> ctrl == ($past(wdata) & bank_pkg::CTRL_MASK))
		else $error("control write did not land");
	a_dbg_write: assert property (
		wr_en && addr == bank_pkg::OFS_DBGCTRL |=> dbg == $past(wdata))
		else $error("debug write did not land");
	// Reserved control bits never leave the block as ones
	a_ctrl_reserved: assert property (
		ctrl_out[7:4] == 4'h0)
		else $error("reserved control bits set");
	// Command strobe: taken writes pulse, soft reset swallows them
	a_cmd_taken: assert property (
		wr_en && addr == bank_pkg::OFS_CMD && !soft_rst
		|=> cmd_pulse && cmd_value == $past(wdata))
		else $error("command write gave no pulse");
	a_cmd_dropped: assert property (
		wr_en && addr == bank_pkg::OFS_CMD && soft_rst
		|=> !cmd_pulse && $stable(cmd_value))
		else $error("command write survived soft reset");
	// Read answer stands one cycle only, zero when idle
	a_rd_answer: assert property (
		!rd_en |=> !rd_valid && rdata == 8'h00)
		else $error("read answer without a read");
	a_rd_valid: assert property (
		rd_en |=> rd_valid)
		else $error("read gave no valid pulse");
	// Shared storage moves only on a data write or soft reset
	a_store_held: assert property (
		!(wr_en && addr[2]) && !soft_rst |=> $stable(data_bus.value))
		else $error("data storage changed without a write");
	a_data_lag: assert property (
		data_out == $past(data_bus.value))
		else $error("data output does not trail the storage");
endmodule

// *** verif/reg_bank_tb.sv ***
// Self-checking bench for the set/clear/toggle register bank.
// Assumes bank_pkg is compiled first; the bench drives every port itself.
`define CHK(n, e, g) \
	begin \
		n_checks++; \
		if ((g) !== (e)) \
		begin \
			n_fail++; \
			$display("mismatch %s exp %h got %h", n, e, g); \
		end \
	end

module reg_bank_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic soft_rst = 1'b0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [2:0] addr, a;
	logic [7:0] wdata, status_in, rdata, ctrl_out, data_out, dbg_out;
	logic [7:0] cmd_value, ctrl, dbg, data, cmd, sts, v;
	logic rd_valid, cmd_pulse;
	logic [1:0] pc;
	int n_fail = 0;
	int n_checks = 0;

	// 250 MHz clock
	always #2 mclk = ~mclk;

	reg_bank dut (.mclk(mclk), .rst(rst), .soft_rst(soft_rst),
		.wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
		.status_in(status_in), .rdata(rdata), .rd_valid(rd_valid),
		.ctrl_out(ctrl_out), .data_out(data_out), .dbg_out(dbg_out),
		.cmd_pulse(cmd_pulse), .cmd_value(cmd_value));

	// -----------------------------------------------------------------
	// Expected values
	// -----------------------------------------------------------------
	// Read value per offset; write-only reads as the chosen fill
	function automatic logic [7:0] expect_rd(input logic [2:0] ad);
		case (ad)
			bank_pkg::OFS_CTRL: return ctrl & bank_pkg::CTRL_MASK;
			bank_pkg::OFS_STATUS: return sts;
			bank_pkg::OFS_CMD: return bank_pkg::WO_READ;
			bank_pkg::OFS_DBGCTRL: return dbg;
			default: return data;
		endcase
	endfunction

	// Shared storage after a write through base or alias
	function automatic logic [7:0] next_data(input logic [2:0] ad,
		input logic [7:0] cur, input logic [7:0] w);
		case (ad)
			bank_pkg::OFS_DATA_SET: return cur | w;
			bank_pkg::OFS_DATA_CLEAR: return cur & ~w;
			bank_pkg::OFS_DATA_TOGGLE: return cur ^ w;
			default: return w;
		endcase
	endfunction

	// -----------------------------------------------------------------
	// Access tasks
	// -----------------------------------------------------------------
	// One write; pulse is counted over two cycles as its slot may lag
	task automatic wr(input logic [2:0] ad, input logic [7:0] w);
		@(negedge mclk);
		wr_en = 1'b1;
		addr = ad;
		wdata = w;
		@(negedge mclk);
		wr_en = 1'b0;
		pc = {1'b0, cmd_pulse};
		if (ad == bank_pkg::OFS_CTRL)
			ctrl = w & bank_pkg::CTRL_MASK;
		else if (ad == bank_pkg::OFS_DBGCTRL)
			dbg = w;
		else if (ad == bank_pkg::OFS_CMD)
			cmd = w;
		else if (ad >= bank_pkg::OFS_DATA)
			data = next_data(ad, data, w);
		@(negedge mclk);
		pc = pc + {1'b0, cmd_pulse};
		`CHK("cmd_pulse", {1'b0, ad == bank_pkg::OFS_CMD}, pc)
		`CHK("cmd_value", cmd, cmd_value)
		`CHK("ctrl_out", ctrl, ctrl_out)
		`CHK("dbg_out", dbg, dbg_out)
		`CHK("data_out", data, data_out)
	endtask

	// One read, answer sampled in the cycle after the taking edge
	task automatic rd(input logic [2:0] ad);
		@(negedge mclk);
		rd_en = 1'b1;
		addr = ad;
		@(negedge mclk);
		rd_en = 1'b0;
		`CHK("rd_valid", 1'b1, rd_valid)
		`CHK("rdata", expect_rd(ad), rdata)
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial
	begin
		{addr, wdata, status_in, ctrl, dbg, data, cmd, sts} = '0;
		void'($urandom(32'hD849));
		repeat (8) @(negedge mclk);
		rst = 1'b0;
		for (int i = 0; i < 8; i++)
			rd(3'(i));
		$display("test reset done");
		// Ones into reserved positions must still read back as zero
		wr(bank_pkg::OFS_CTRL, 8'hFF);
		rd(bank_pkg::OFS_CTRL);
		// Random traffic; software keeps reserved bits zero
		repeat (60)
		begin
			a = 3'($urandom_range(7));
			v = 8'($urandom);
			if (a == bank_pkg::OFS_CTRL)
				v = v & bank_pkg::CTRL_MASK;
			wr(a, v);
			rd(3'($urandom_range(7)));
		end
		$display("test random done");
		// Alias corners: all-zero masks change nothing, then full toggle, partial clear and set
		wr(bank_pkg::OFS_DATA, 8'hA5);
		wr(bank_pkg::OFS_DATA_SET, 8'h00);
		wr(bank_pkg::OFS_DATA_CLEAR, 8'h00);
		wr(bank_pkg::OFS_DATA_TOGGLE, 8'hFF);
		wr(bank_pkg::OFS_DATA_CLEAR, 8'hF0);
		wr(bank_pkg::OFS_DATA_SET, 8'h81);
		for (int i = 4; i < 8; i++)
			rd(3'(i));
		$display("test alias done");
		// Status follows pins after the synchroniser, ignores writes
		status_in = 8'($urandom);
		sts = status_in;
		repeat (4) @(negedge mclk);
		rd(bank_pkg::OFS_STATUS);
		wr(bank_pkg::OFS_STATUS, ~sts);
		rd(bank_pkg::OFS_STATUS);
		$display("test status done");
		// Soft reset clears control and data but spares debug
		wr(bank_pkg::OFS_CTRL, 8'h05);
		wr(bank_pkg::OFS_DBGCTRL, 8'h3C);
		wr(bank_pkg::OFS_DATA, 8'h81);
		@(negedge mclk);
		soft_rst = 1'b1;
		@(negedge mclk);
		soft_rst = 1'b0;
		ctrl = bank_pkg::CTRL_RST;
		data = bank_pkg::DATA_RST;
		rd(bank_pkg::OFS_CTRL);
		rd(bank_pkg::OFS_DATA);
		rd(bank_pkg::OFS_DBGCTRL);
		// Soft reset swallows a command write but lets debug land
		@(negedge mclk);
		soft_rst = 1'b1;
		wr_en = 1'b1;
		addr = bank_pkg::OFS_CMD;
		wdata = 8'h5A;
		@(negedge mclk);
		addr = bank_pkg::OFS_DBGCTRL;
		`CHK("cmd_pulse", 1'b0, cmd_pulse)
		@(negedge mclk);
		soft_rst = 1'b0;
		wr_en = 1'b0;
		dbg = 8'h5A;
		`CHK("cmd_value", cmd, cmd_value)
		`CHK("dbg_out", dbg, dbg_out)
		rd(bank_pkg::OFS_DBGCTRL);
		rd(bank_pkg::OFS_CTRL);
		$display("test soft reset done");
		stop_test;
	end
endmodule
